/* File: ide_bus_pkg.sv */
package ide_bus_pkg;
  // Register map (plain port, byte addresses)
  localparam logic [3:0] ADDR_AUX_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_HIGH_BYTE = 4'h1;
  localparam logic [3:0] ADDR_PORT_SFR = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  // aux_control_reg fields
  localparam int BIT_WIDE = 0;
  localparam int BIT_STRETCH = 1;
  localparam int BIT_DOUBLE_SPEED = 2;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  localparam logic [7:0] SFR_RESET = 8'hff;
  // Timing in CPU clock periods (OSC_PER_CPU_STD and OSC_PER_CPU_X2: oscillator periods per CPU clock)
  localparam int CYCLE_CPU_CLOCKS = 6;
  localparam int STROBE_NORMAL = 3;
  localparam int STROBE_STRETCH = 15;
  localparam int OSC_PER_CPU_STD = 2;
  localparam int OSC_PER_CPU_X2 = 1;
  localparam int ALE_CPU_CLOCKS = 1;
  // Address mode of a move
  localparam logic [1:0] MODE_DPTR = 2'h0;
  localparam logic [1:0] MODE_RI = 2'h1;
endpackage

/* File: cpu_clock_divider.sv */
`timescale 1ns/1ps
module cpu_clock_divider
  import ide_bus_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_double_speed,
  output logic o_tick
);
  logic [1:0] count;

  // Standard mode takes two oscillator periods per CPU clock, double-speed one
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count <= 2'h0;
      o_tick <= 1'b0;
    end else if (i_double_speed || count == 2'(OSC_PER_CPU_STD - 1)) begin
      count <= 2'h0;
      o_tick <= 1'b1;
    end else begin
      count <= count + 2'h1;
      o_tick <= 1'b0;
    end
  end
endmodule

/* File: ide_sixteen_bit_bus_port.sv */
`timescale 1ns/1ps
// Functional notes
// R01: With wide access enabled every external move is a 16-bit transfer.
// R02: Low port carries low address and data, high port carries high address and data.
// R03: A wide write drives the working byte low and the holding register high.
// R04: A wide read returns the low byte to the core and loads the holding register.
// R05: A wide bus cycle lasts 6 CPU clocks (12 oscillator clocks standard, 6 double speed).
// R06: The stretch bit widens read and write strobes from 3 to 15 CPU clocks.
// R07: An 8-bit indirect move puts the high port register on the high port.
// R08: A pointer move with page access mode puts the high port register on the high port.
// R09: The address latch strobe marks valid address on the low address/data lines.
// R10: The attached disk uses the read strobe as I/O read and the write strobe as I/O write.
// R11: Other disk controls come from an external address latch or from port pins.
// R12: With wide access clear moves are 8-bit and the holding register is untouched.
module ide_sixteen_bit_bus_port
  import ide_bus_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [7:0] o_reg_rdata,
  input wire logic i_move_start,
  input wire logic i_move_is_write,
  input wire logic [1:0] i_move_mode,
  input wire logic i_page_access_mode_bit,
  input wire logic [15:0] i_move_address,
  input wire logic [7:0] i_cpu_working_byte,
  output logic [7:0] o_read_byte,
  output logic o_move_done,
  output logic o_move_busy,
  input wire logic [7:0] i_low_port,
  output logic [7:0] o_low_port,
  output logic o_low_port_oe,
  input wire logic [7:0] i_high_port,
  output logic [7:0] o_high_port,
  output logic o_high_port_oe,
  output logic o_addr_latch,
  output logic o_read_strobe_n,
  output logic o_write_strobe_n
);
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    ADDR = 2'b01,
    STROBE = 2'b10,
    TAIL = 2'b11
  } phase_type;

  phase_type phase;
  logic [7:0] aux_control_reg;
  logic [7:0] high_byte_holding;
  logic [7:0] high_port_sfr;
  logic cpu_tick;
  logic [3:0] count;
  logic wide;
  logic is_write;
  logic sfr_high;
  logic [15:0] address;
  logic [7:0] write_low;
  logic [7:0] write_high;
  logic [3:0] strobe_len;
  logic [3:0] tail_len;
  logic last_tick;
  logic capture;

  // ------------------------------------------------------------
  // CPU clock enable
  // ------------------------------------------------------------
  cpu_clock_divider u_div (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_double_speed(aux_control_reg[BIT_DOUBLE_SPEED]),
    .o_tick(cpu_tick)
  );

  // ------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------
  // Address, strobe and tail sum to 6 CPU clocks unstretched
  assign strobe_len = aux_control_reg[BIT_STRETCH] ? 4'(STROBE_STRETCH) : 4'(STROBE_NORMAL); // R06
  assign tail_len = 4'(CYCLE_CPU_CLOCKS - STROBE_NORMAL - ALE_CPU_CLOCKS); // R05
  assign last_tick = cpu_tick && count == 4'h1;
  assign capture = phase == STROBE && last_tick && !is_write;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      phase <= IDLE;
      count <= 4'h0;
    end else begin
      unique case (phase)
        IDLE: begin
          if (i_move_start) begin
            phase <= ADDR;
            count <= 4'(ALE_CPU_CLOCKS);
          end
        end
        ADDR: begin
          if (last_tick) begin
            phase <= STROBE;
            count <= strobe_len;
          end else if (cpu_tick) begin
            count <= count - 4'h1;
          end
        end
        STROBE: begin
          if (last_tick) begin
            phase <= TAIL;
            count <= tail_len;
          end else if (cpu_tick) begin
            count <= count - 4'h1;
          end
        end
        TAIL: begin
          if (last_tick) begin
            phase <= IDLE;
          end else if (cpu_tick) begin
            count <= count - 4'h1;
          end
        end
      endcase
    end
  end

  // Request is latched so the core may change its lines during the cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wide <= 1'b0;
      is_write <= 1'b0;
      sfr_high <= 1'b0;
      address <= 16'h0000;
      write_low <= 8'h00;
      write_high <= 8'h00;
    end else if (phase == IDLE && i_move_start) begin
      wide <= aux_control_reg[BIT_WIDE]; // R01 R12
      is_write <= i_move_is_write;
      sfr_high <= (i_move_mode == MODE_RI) || i_page_access_mode_bit; // R07 R08
      address <= i_move_address;
      write_low <= i_cpu_working_byte; // R03
      write_high <= high_byte_holding; // R03
    end
  end

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_low_port <= 8'h00;
      o_low_port_oe <= 1'b0;
      o_high_port <= 8'h00;
      o_high_port_oe <= 1'b0;
      o_addr_latch <= 1'b0;
      o_read_strobe_n <= 1'b1;
      o_write_strobe_n <= 1'b1;
    end else begin
      o_addr_latch <= phase == ADDR; // R09
      o_read_strobe_n <= !(phase == STROBE && !is_write); // R10
      o_write_strobe_n <= !(phase == STROBE && is_write); // R10
      // Low port: address, then write data or released for read
      o_low_port <= (phase == ADDR) ? address[7:0] : write_low; // R02
      o_low_port_oe <= phase == ADDR || (phase != IDLE && is_write);
      // High port drives data only on a wide write; an 8-bit move holds the address
      if (phase == ADDR || !wide) begin
        o_high_port <= sfr_high ? high_port_sfr : address[15:8]; // R02 R07 R08 R12
      end else begin
        o_high_port <= write_high; // R02 R03
      end
      o_high_port_oe <= phase != IDLE && (phase == ADDR || !wide || is_write); // R12
    end
  end

  // ------------------------------------------------------------
  // Core side answer
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_read_byte <= 8'h00;
      o_move_done <= 1'b0;
      o_move_busy <= 1'b0;
    end else begin
      o_move_done <= phase == TAIL && last_tick;
      o_move_busy <= phase != IDLE;
      if (capture) begin
        o_read_byte <= i_low_port; // R04
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      aux_control_reg <= AUX_RESET;
      high_port_sfr <= SFR_RESET;
    end else if (i_reg_write) begin
      if (i_reg_addr == ADDR_AUX_CONTROL) begin
        aux_control_reg <= {5'h00, i_reg_wdata[2:0]};
      end
      if (i_reg_addr == ADDR_PORT_SFR) begin
        high_port_sfr <= i_reg_wdata;
      end
    end
  end

  // Bus capture wins over a software write in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      high_byte_holding <= HIGH_RESET;
    end else if (capture && wide) begin
      high_byte_holding <= i_high_port; // R04 R12
    end else if (i_reg_write && i_reg_addr == ADDR_HIGH_BYTE) begin
      high_byte_holding <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_read) begin
      unique case (i_reg_addr)
        ADDR_AUX_CONTROL: o_reg_rdata <= aux_control_reg;
        ADDR_HIGH_BYTE: o_reg_rdata <= high_byte_holding;
        ADDR_PORT_SFR: o_reg_rdata <= high_port_sfr;
        ADDR_STATUS: o_reg_rdata <= {6'h00, wide, phase != IDLE};
        default: o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end
endmodule

/* File: ide_bus_port_assertions.sv */
`timescale 1ns/1ps
module ide_bus_port_checker (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_move_start,
  input wire logic o_move_busy,
  input wire logic o_move_done,
  input wire logic o_low_port_oe,
  input wire logic o_high_port_oe,
  input wire logic o_addr_latch,
  input wire logic o_read_strobe_n,
  input wire logic o_write_strobe_n
);
  // ----
  // Strobe width counter
  // ----
  int low_count;
  always_ff @(posedge i_clock) begin
    if (i_rst || (o_read_strobe_n && o_write_strobe_n)) low_count <= 0;
    else low_count <= low_count + 1;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  AST_STROBE_EXCL: assert property (o_read_strobe_n || o_write_strobe_n)
    else $error("both strobes low");
  AST_ALE_ADDR: assert property (o_addr_latch |-> o_low_port_oe && o_read_strobe_n)
    else $error("latch strobe without address drive");
  AST_READ_FREE: assert property (!o_read_strobe_n |-> !o_low_port_oe)
    else $error("low port driven in read");
  AST_WRITE_DRIVE: assert property (!o_write_strobe_n |-> o_low_port_oe && o_high_port_oe)
    else $error("ports released in write");
  AST_BUSY_RISE: assert property (i_move_start && !o_move_busy |-> ##[1:3] o_move_busy)
    else $error("move not started");
  AST_DONE_TIME: assert property ($rose(o_move_busy) |-> ##[2:50] o_move_done)
    else $error("move too long");
  AST_DONE_PULSE: assert property (o_move_done |=> !o_move_done)
    else $error("done too long");
  AST_STROBE_LEN: assert property ($rose(o_read_strobe_n && o_write_strobe_n)
    |-> low_count inside {3, 6, 15, 30}) else $error("bad strobe width");
  cover property (low_count == 30);
  cover property ($rose(o_addr_latch));
  cover property (!o_read_strobe_n);
endmodule
bind ide_sixteen_bit_bus_port ide_bus_port_checker ide_bus_port_checker_inst (.i_clock, .i_rst,
  .i_move_start, .o_move_busy, .o_move_done, .o_low_port_oe, .o_high_port_oe, .o_addr_latch,
  .o_read_strobe_n, .o_write_strobe_n);

/* File: ide_disk_model.sv */
`timescale 1ns/1ps
module ide_disk_model (
  input wire logic i_clock,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_lo_oe,
  input wire logic i_hi_oe,
  input wire logic [7:0] i_lo,
  input wire logic [7:0] i_hi,
  input wire logic [15:0] i_rd_word,
  output logic [7:0] o_lo,
  output logic [7:0] o_hi,
  output logic [15:0] o_addr,
  output logic [15:0] o_wr_word
);
  logic [15:0] last = 16'h0000;
  // Released lines show the read word while the read strobe is low, else the inverse of the last level so stale data never matches
  assign o_lo = i_lo_oe ? i_lo : !i_rd_n ? i_rd_word[7:0] : ~last[7:0];
  assign o_hi = i_hi_oe ? i_hi : !i_rd_n ? i_rd_word[15:8] : ~last[15:8];
  always_ff @(posedge i_clock) begin
    last <= {o_hi, o_lo};
    if (i_ale) o_addr <= {o_hi, o_lo};
    if (!i_wr_n) o_wr_word <= {o_hi, o_lo};
  end
endmodule

/* File: ide_sixteen_bit_bus_port_tb_top.sv */
`timescale 1ns/1ps
module ide_sixteen_bit_bus_port_tb_top;
  import ide_bus_pkg::*;
  logic i_clock = 0, i_rst = 1, i_reg_write = 0, i_reg_read = 0, i_move_start = 0;
  logic i_move_is_write = 0, i_page_access_mode_bit = 0, o_move_done, o_move_busy;
  logic o_low_port_oe, o_high_port_oe, o_addr_latch, o_read_strobe_n, o_write_strobe_n;
  logic [1:0] i_move_mode = 0;
  logic [3:0] i_reg_addr = 0;
  logic [7:0] i_reg_wdata = 0, i_cpu_working_byte = 0, o_reg_rdata, o_read_byte;
  logic [7:0] i_low_port, o_low_port, i_high_port, o_high_port;
  logic [15:0] i_move_address = 0, seen_addr, seen_word, rword = 16'h9e3c;
  int err_count = 0, check_count = 0, n;
  ide_sixteen_bit_bus_port ide_sixteen_bit_bus_port_inst (.i_clock, .i_rst, .i_reg_addr,
    .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata, .i_move_start, .i_move_is_write,
    .i_move_mode, .i_page_access_mode_bit, .i_move_address, .i_cpu_working_byte, .o_read_byte,
    .o_move_done, .o_move_busy, .i_low_port, .o_low_port, .o_low_port_oe, .i_high_port,
    .o_high_port, .o_high_port_oe, .o_addr_latch, .o_read_strobe_n, .o_write_strobe_n);
  ide_disk_model ide_disk_model_inst (.i_clock, .i_ale(o_addr_latch), .i_rd_n(o_read_strobe_n),
    .i_wr_n(o_write_strobe_n), .i_lo_oe(o_low_port_oe), .i_hi_oe(o_high_port_oe),
    .i_lo(o_low_port), .i_hi(o_high_port), .i_rd_word(rword), .o_lo(i_low_port),
    .o_hi(i_high_port), .o_addr(seen_addr), .o_wr_word(seen_word));
  initial begin
    forever #2.5 i_clock = ~i_clock;
  end
  // ----
  // Access tasks
  // ----
  task automatic check(string s, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rw(logic [3:0] a, logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask
  task automatic rc(logic [3:0] a, logic [7:0] e);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    #1 check("reg", o_reg_rdata, e);
  endtask
  // Start is taken only while idle, so one spare edge follows every done
  task automatic mv(logic w, logic [1:0] m, logic p, logic [15:0] ad, logic [7:0] b);
    @(posedge i_clock);
    i_move_start <= 1'b1;
    i_move_is_write <= w;
    i_move_mode <= m;
    i_page_access_mode_bit <= p;
    i_move_address <= ad;
    i_cpu_working_byte <= b;
    @(posedge i_clock);
    i_move_start <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clock);
      #1 n++;
      if (n == 1) check("busy", o_move_busy, 16'h0001);
    end while (o_move_done !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_count++;
      close_out();
    end
    @(posedge i_clock);
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    int e;
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    rc(ADDR_AUX_CONTROL, AUX_RESET);
    rc(ADDR_HIGH_BYTE, HIGH_RESET);
    rc(ADDR_PORT_SFR, SFR_RESET);
    rc(4'hf, 8'h00);
    rc(ADDR_STATUS, 8'h00);
    rw(ADDR_PORT_SFR, 8'h77);
    rw(ADDR_HIGH_BYTE, 8'hc3);
    mv(1'b1, MODE_DPTR, 1'b0, 16'h1234, 8'h5a);
    check("addr", seen_addr, 16'h1234);
    check("narrow", seen_word, 16'h125a);
    mv(1'b0, MODE_DPTR, 1'b0, 16'h1234, 8'h00);
    check("rbyte", o_read_byte, 16'h003c);
    rc(ADDR_HIGH_BYTE, 8'hc3);
    mv(1'b1, MODE_RI, 1'b0, 16'h12ab, 8'h01);
    check("ri", seen_addr, 16'h77ab);
    mv(1'b1, MODE_DPTR, 1'b1, 16'h12ab, 8'h01);
    check("page", seen_addr, 16'h77ab);
    rw(ADDR_AUX_CONTROL, 8'h01);
    rc(ADDR_AUX_CONTROL, 8'h01);
    mv(1'b1, MODE_DPTR, 1'b0, 16'h4321, 8'h5a);
    check("wide", seen_word, 16'hc35a);
    rc(ADDR_STATUS, 8'h02);
    check("waddr", seen_addr, 16'h4321);
    rword = 16'h6b2d;
    mv(1'b0, MODE_DPTR, 1'b0, 16'h4321, 8'h00);
    check("wlow", o_read_byte, 16'h002d);
    rc(ADDR_HIGH_BYTE, 8'h6b);
    for (int i = 0; i < 8; i++) begin
      rw(ADDR_AUX_CONTROL, 8'(2 * (i % 4) + 1));
      mv(i[2], MODE_DPTR, 1'b0, 16'h0101, 8'h11);
      e = CYCLE_CPU_CLOCKS + (i[0] ? STROBE_STRETCH - STROBE_NORMAL : 0);
      e = e * (i[1] ? OSC_PER_CPU_X2 : OSC_PER_CPU_STD);
      check("cycle", 16'(n inside {[e - 1:e]}), 16'h0001);
    end
    close_out();
  end
endmodule
